// ### asq_fifo.sv
// Small synchronous FIFO with valid/ready on both sides.
// Assumes one clock and a synchronous active-low reset.
`default_nettype none
module asq_fifo #(
    parameter int W     = 10,
    parameter int DEPTH = 4
) (
    // Clock and reset
    input wire logic mclk,
    input wire logic rst_n,
    // Ports
    asq_fifo_if.fifo f
);
    localparam int AW = $clog2(DEPTH);
    initial if (DEPTH < 2 || (1 << AW) != DEPTH) $error("DEPTH must be a power of two");

    logic [W-1:0]  mem [DEPTH];   // Storage
    logic [AW:0]   wrPtr_r;       // Write pointer with wrap bit
    logic [AW:0]   rdPtr_r;       // Read pointer with wrap bit
    logic          doWr;
    logic          doRd;

    // Full when pointers differ only in wrap bit
    assign f.inReady  = (wrPtr_r ^ rdPtr_r) != {1'b1, {AW{1'b0}}};
    assign f.outValid = wrPtr_r != rdPtr_r;
    assign f.outData  = mem[rdPtr_r[AW-1:0]];
    assign doWr       = f.inValid && f.inReady;
    assign doRd       = f.outValid && f.outReady;

    // ==========================================
    // Pointer update
    always_ff @(posedge mclk)
    begin
        if (!rst_n)
        begin
            wrPtr_r <= '0;
            rdPtr_r <= '0;
        end
        else
        begin
            if (doWr)
                wrPtr_r <= wrPtr_r + 1'b1;
            if (doRd)
                rdPtr_r <= rdPtr_r + 1'b1;
        end
    end

    // Storage write, no reset needed on data
    always_ff @(posedge mclk)
    begin
        if (doWr)
            mem[wrPtr_r[AW-1:0]] <= f.inData;
    end
endmodule
`default_nettype wire

// ### asq_fifo_if.sv
// Interface carrying results from the converter into the result FIFO and out again.
// Assumes both ends run on the same clock.
`default_nettype none
interface asq_fifo_if #(parameter int W = 10);
    logic         inValid;   // Producer has a word
    logic         inReady;   // FIFO can take it
    logic [W-1:0] inData;    // Word in
    logic         outValid;  // FIFO holds a word
    logic         outReady;  // Consumer takes it
    logic [W-1:0] outData;   // Word out
    modport fifo (input inValid, inData, outReady, output inReady, outValid, outData);
    modport user (output inValid, inData, outReady, input inReady, outValid, outData);
endinterface
`default_nettype wire

// ### asq_host.sv
// Host serial master model: shift clock, chip select and channel address.
// Assumes the caller spaces transfers; the shift clock stands low between frames.
`default_nettype none
module asq_host (
    // Serial pins
    output var logic sclk   = 1'b0,
    output var logic csN    = 1'b1,
    output var logic dataIn = 1'b0,
    input wire logic dataOut
);
    timeunit 1ns;
    timeprecision 100ps;
    // One transfer of n clocks; an 80 ns period keeps the run short
    task automatic xfer(input int n, input logic [3:0] addr, input int gapNs,
                        output logic [15:0] rd);
        rd  = 16'h0000;
        csN = 1'b0;
        #300;
        for (int i = 0; i < n; i++)
        begin
            // Address MSB first, then a toggling pattern the device must ignore
            dataIn = (i < 4) ? addr[3 - i] : ~dataIn;
            #40 rd[15 - i] = dataOut;
            sclk = 1'b1;
            #40 sclk = 1'b0;
            if (i == 9)
                #(gapNs);
        end
        // Release between frames permits any count from 10 to 16
        #40 csN = 1'b1;
        dataIn = ~dataIn;
    endtask
    // Reselect shortly after the tenth fall to cut the conversion off
    task automatic abortPulse();
        #150 csN = 1'b0;
        #300 csN = 1'b1;
    endtask
endmodule
`default_nettype wire

// ### asq_pkg.sv
// Package for the serial conversion sequencer: pin protocol counts and timing constants.
// Assumes a single 100 MHz system clock; all times are converted to cycle counts here.
`default_nettype none
package asq_pkg;
    // ==========================================
    // Clock
    localparam int CLK_MHZ         = 100;
    // ==========================================
    // Transfer shape
    localparam int RES_BITS        = 10;
    localparam int ADDR_BITS       = 4;
    localparam int MIN_CLKS        = 10;
    localparam int MAX_CLKS        = 16;
    localparam int ACQ_CLKS        = 6;
    localparam logic [4:0] ADDR_RISES    = 5'h04;
    localparam logic [4:0] ACQ_START_FALL = 5'h04;
    localparam logic [4:0] EOT_FALL      = 5'h0A;
    localparam logic [4:0] LONG_FALL     = 5'h10;
    // ==========================================
    // Times in their own units
    localparam int CONV_MAX_US     = 44;
    localparam int ABORT_WIN_US    = 9;
    localparam int RISE_GAP_NS     = 18500;
    // Longest times round down
    localparam int CONV_CYC        = CONV_MAX_US * CLK_MHZ;
    localparam int ABORT_WIN_CYC   = ABORT_WIN_US * CLK_MHZ;
    localparam int RISE_GAP_CYC    = (RISE_GAP_NS * CLK_MHZ) / 1000;
    // ==========================================
    // Sequencer states
    typedef enum logic [1:0] {SQ_IDLE, SQ_SHIFT, SQ_CONV} asq_state_t;
endpackage
`default_nettype wire

// ### asq_seq_chk.sv
// Checker of the sequencer pins: outputs tied to the serial inputs that cause them.
// Assumes it is bound to asq_sequencer and sees only that module's ports.
`default_nettype none
module asq_seq_chk #(
    parameter int CONV_CYCLES  = asq_pkg::CONV_CYC,
    parameter int ABORT_CYCLES = asq_pkg::ABORT_WIN_CYC
) (
    // Clock and reset
    input wire logic       mclk,
    input wire logic       rst_n,
    // Serial pins
    input wire logic       sclk,
    input wire logic       csN,
    input wire logic       dataOut,
    input wire logic       dataOutEn,
    input wire logic       eocOut,
    // Front end and status
    input wire logic [3:0] analogChannelSel,
    input wire logic       sampleEn,
    input wire logic       syncLost
);
    timeunit 1ns;
    timeprecision 100ps;
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!rst_n);
    // ====
    // Helpers
    logic        sclkQ_r;  // Shift clock one cycle back
    logic [11:0] idle_r;   // Cycles since the shift clock moved
    logic [11:0] lastGap_r; // Length of the last still stretch of the clock
    logic [15:0] low_r;    // Cycles of the conversion so far
    // Saturates so a parked clock never wraps back to zero
    always_ff @(posedge mclk)
    begin
        sclkQ_r <= sclk;
        if (sclk != sclkQ_r)
            lastGap_r <= idle_r;
        if (!rst_n || sclk != sclkQ_r)
            idle_r <= 12'h000;
        else if (idle_r != 12'hFFF)
            idle_r <= idle_r + 12'h001;
    end
    // Runs while the end-of-conversion flag is low
    always_ff @(posedge mclk)
    begin
        if (!rst_n || eocOut)
            low_r <= 16'h0000;
        else
            low_r <= low_r + 16'h0001;
    end
    // Select falls and stays low long enough to pass the synchroniser
    sequence s_cs_taken;
        $fell(csN) ##1 !csN [*5];
    endsequence
    // ====
    // Properties
    a_hiz_idle: assert property (csN [*5] |-> !dataOutEn)
        else $error("result output driven while deselected");
    a_low_in_conv: assert property (!eocOut && !$past(eocOut) && $past(dataOutEn, 4)
        && $past(dataOutEn) |-> !$past(dataOut)) else $error("nonzero bit during conversion");
    a_eoc_after_acq: assert property ($fell(eocOut) |-> $past(sampleEn) || $past(sampleEn, 2))
        else $error("conversion began without acquisition");
    a_acq_steady: assert property ($rose(sampleEn) |=>
        (sampleEn && $stable(analogChannelSel)) [*8]) else $error("acquisition cut short");
    a_conv_bound: assert property (!eocOut |-> low_r < CONV_CYCLES)
        else $error("conversion too long");
    a_sync_gap: assert property ($rose(syncLost) |-> !csN
        && lastGap_r >= asq_pkg::RISE_GAP_CYC - 4) else $error("sync lost before the gap limit");
    a_sync_clear: assert property (syncLost ##0 s_cs_taken |-> !syncLost)
        else $error("sync loss not cleared by select");
    a_abort_fast: assert property ((!eocOut && low_r < ABORT_CYCLES - 10) ##0 s_cs_taken
        |-> ##[0:4] eocOut) else $error("reselect did not abort");
endmodule
`default_nettype wire

// ### asq_sequencer.sv
// Serial interface and conversion sequencer of a 10-bit converter.
// Assumes the shift clock, chip select and data input arrive asynchronously;
// the analog comparator is modelled by a sample input taken at each step.
`default_nettype none
// What this block does
// - Transfers last ten to sixteen shift clocks
// - Six shift-clock acquisition window per transfer
// - Conversion finishes within 44 microseconds
// - Chip-select toggle within 9 us aborts
// - Chip-select edge accepted right after EOC
// - Sixteen-clock transfers are accepted
// - Result out MSB first, then low
// - Four address bits on first rises
// - EOC low at tenth fall, high when done
module asq_sequencer #(
    parameter int CONV_CYCLES  = asq_pkg::CONV_CYC,
    parameter int ABORT_CYCLES = asq_pkg::ABORT_WIN_CYC
) (
    // Clock and reset
    input  wire logic       mclk,
    input  wire logic       rst_n,
    // Serial pins
    input  wire logic       sclk,
    input  wire logic       csN,
    input  wire logic       dataIn,
    output var  logic       dataOut,
    output var  logic       dataOutEn,
    output var  logic       eocOut,
    // Analog front end
    output var  logic [3:0] analogChannelSel,
    output var  logic       sampleEn,
    input  wire logic       cmpHigh,
    // Status
    output var  logic       syncLost
);
    initial if (CONV_CYCLES < 2*asq_pkg::RES_BITS || ABORT_CYCLES < 1)
        $error("Conversion or abort count too small");

    localparam int STEP_CYC = CONV_CYCLES / (asq_pkg::RES_BITS + 1);
    localparam int RG = asq_pkg::RISE_GAP_CYC;

    // ==========================================
    // Pin synchronisers
    logic [1:0] sclkS_r, csS_r, dinS_r;  // Two flops each
    logic       sclkD_r;                  // Previous synced clock
    logic       csD_r;                    // Previous synced select
    always_ff @(posedge mclk)
    begin
        if (!rst_n)
        begin
            sclkS_r <= 2'h0;
            csS_r   <= 2'h3;
            dinS_r  <= 2'h0;
            sclkD_r <= 1'b0;
            csD_r   <= 1'b1;
        end
        else
        begin
            sclkS_r <= {sclkS_r[0], sclk};
            csS_r   <= {csS_r[0], csN};
            dinS_r  <= {dinS_r[0], dataIn};
            sclkD_r <= sclkS_r[1];
            csD_r   <= csS_r[1];
        end
    end
    logic sRise, sFall, csFall, csLow;
    assign csLow  = !csS_r[1];
    assign sRise  = csLow && sclkS_r[1] && !sclkD_r;
    assign sFall  = csLow && !sclkS_r[1] && sclkD_r;
    assign csFall = !csS_r[1] && csD_r;

    // ==========================================
    // Result FIFO between converter and shift-out
    asq_fifo_if #(.W(asq_pkg::RES_BITS)) rq ();
    asq_fifo #(.W(asq_pkg::RES_BITS), .DEPTH(4)) uFifo (
        .mclk  (mclk),
        .rst_n (rst_n),
        .f     (rq.fifo)
    );

    asq_pkg::asq_state_t state_r;
    logic [4:0]  rises_r;                        // Rising edges this transfer
    logic [4:0]  falls_r;                        // Falling edges this transfer
    logic [3:0]  addr_r;                         // Address being shifted in
    logic [9:0]  shOut_r;                        // Result shift register
    logic [9:0]  result_r;                       // Output result register
    logic [9:0]  sar_r;                          // Approximation register
    logic [3:0]  bitIdx_r;                       // Current trial bit
    logic [15:0] stepCnt_r;                      // Cycles within a step
    logic [15:0] sinceTenth_r;                   // Cycles since tenth fall
    logic        riseSeen_r;                     // Rise after tenth fall
    logic        convDone;
    logic        tenthFall;                      // Tenth fall of a frame
    logic [9:0]  newRes;                         // Result of the final step

    // Pop at once: the same word is also kept in result_r for later frames
    assign rq.outReady = 1'b1;

    // ==========================================
    // Transfer counters and address capture
    always_ff @(posedge mclk)
    begin
        if (!rst_n || csS_r[1] || csFall)
        begin
            rises_r <= 5'h00;
            falls_r <= 5'h00;
            if (!rst_n)
                addr_r <= 4'h0;
        end
        else
        begin
            if (sRise && rises_r < asq_pkg::LONG_FALL)
                rises_r <= rises_r + 5'h01;
            if (sRise && rises_r < asq_pkg::ADDR_RISES)
                addr_r <= {addr_r[2:0], dinS_r[1]};
            if (sFall)
                falls_r <= (falls_r == asq_pkg::LONG_FALL - 5'h01) ? 5'h00
                         : falls_r + 5'h01;
            if (convDone && falls_r == asq_pkg::EOT_FALL)
            begin
                rises_r <= 5'h00;
                falls_r <= 5'h00;
            end
        end
    end

    // Output shift register and drive
    always_ff @(posedge mclk)
    begin
        if (!rst_n)
        begin
            shOut_r   <= 10'h000;
            dataOut   <= 1'b0;
            dataOutEn <= 1'b0;
        end
        else
        begin
            dataOutEn <= csLow;
            // Conversion end reloads only a frame parked at its end; the sixteenth
            // fall reloads only once no conversion is pending
            if (csFall || (rq.outValid && csLow && falls_r == 5'h00)
                || (sFall && falls_r == asq_pkg::LONG_FALL - 5'h01
                    && state_r != asq_pkg::SQ_CONV))
            begin
                shOut_r <= rq.outValid ? rq.outData : result_r;
                dataOut <= rq.outValid ? rq.outData[9] : result_r[9];
            end
            else if (sFall)
            begin
                shOut_r <= {shOut_r[8:0], 1'b0};
                dataOut <= (falls_r < asq_pkg::EOT_FALL - 5'h01) ? shOut_r[8] : 1'b0;
            end
        end
    end

    // ==========================================
    // Sequencer: acquisition, conversion, abort
    always_ff @(posedge mclk)
    begin
        if (!rst_n)
        begin
            state_r      <= asq_pkg::SQ_IDLE;
            sampleEn     <= 1'b0;
            eocOut       <= 1'b1;
            analogChannelSel <= 4'h0;
            sar_r        <= 10'h000;
            bitIdx_r     <= 4'h9;
            stepCnt_r    <= 16'h0000;
            result_r     <= 10'h000;
        end
        else
        begin
            unique case (state_r)
                asq_pkg::SQ_IDLE, asq_pkg::SQ_SHIFT:
                begin
                    // A released select ends any acquisition, even in a cut frame
                    if (!csLow)
                        sampleEn <= 1'b0;
                    if (sFall && falls_r == asq_pkg::ACQ_START_FALL - 5'h01)
                    begin
                        analogChannelSel <= addr_r;
                        sampleEn <= 1'b1;
                    end
                    if (sFall && falls_r == asq_pkg::EOT_FALL - 5'h01)
                    begin
                        sampleEn     <= 1'b0;
                        eocOut       <= 1'b0;
                        state_r      <= asq_pkg::SQ_CONV;
                        sar_r        <= 10'h200;
                        bitIdx_r     <= 4'h9;
                        stepCnt_r    <= 16'h0000;
                    end
                    else if (sRise)
                        state_r <= asq_pkg::SQ_SHIFT;
                end
                asq_pkg::SQ_CONV:
                begin
                    if (csFall && sinceTenth_r < 16'(ABORT_CYCLES))
                    begin
                        state_r  <= asq_pkg::SQ_IDLE;
                        eocOut   <= 1'b1;
                    end
                    else if (stepCnt_r == 16'(STEP_CYC - 1))
                    begin
                        stepCnt_r <= 16'h0000;
                        if (!cmpHigh)
                            sar_r[bitIdx_r] <= 1'b0;
                        if (bitIdx_r == 4'h0)
                        begin
                            result_r <= newRes;
                            eocOut   <= 1'b1;
                            state_r  <= asq_pkg::SQ_IDLE;
                        end
                        else
                        begin
                            bitIdx_r <= bitIdx_r - 4'h1;
                            sar_r[bitIdx_r - 4'h1] <= 1'b1;
                        end
                    end
                    else
                        stepCnt_r <= stepCnt_r + 16'h0001;
                end
            endcase
        end
    end
    assign convDone = state_r == asq_pkg::SQ_CONV && stepCnt_r == 16'(STEP_CYC - 1)
                    && bitIdx_r == 4'h0 && !csFall;

    // Results also queue through the FIFO to reach the shift register
    assign newRes     = {sar_r[9:1], cmpHigh ? sar_r[0] : 1'b0};
    assign rq.inValid = convDone;
    assign rq.inData  = newRes;
    assign tenthFall  = sFall && falls_r == asq_pkg::EOT_FALL - 5'h01;

    // ==========================================
    // Rise watch: a first rise later than the limit after the tenth fall means
    // the host lost step. Limitation: a held-select ten-clock host with a parked
    // clock raises it too, so the flag is advisory and cleared by reselect.
    always_ff @(posedge mclk)
    begin
        if (!rst_n)
        begin
            sinceTenth_r <= 16'h0000;
            riseSeen_r   <= 1'b1;
            syncLost     <= 1'b0;
        end
        else
        begin
            // Saturating age of the last tenth fall, also read by the abort window
            if (tenthFall)
                sinceTenth_r <= 16'h0000;
            else if (sinceTenth_r != 16'hFFFF)
                sinceTenth_r <= sinceTenth_r + 16'h0001;
            // A rise is owed from the tenth fall until it comes or select lifts
            if (tenthFall)
                riseSeen_r <= 1'b0;
            else if (!csLow || sRise)
                riseSeen_r <= 1'b1;
            // Reselect clears; a late rise in the same cycle wins
            if (csFall)
                syncLost <= 1'b0;
            if (sRise && !riseSeen_r && sinceTenth_r > 16'(RG))
                syncLost <= 1'b1;
        end
    end
endmodule
`default_nettype wire

// ### asq_tb.sv
// Top testbench: host model traffic compared with a reference result model.
// Assumes asq_host drives the pins and asq_seq_chk is bound at the foot.
`default_nettype none
module testbench;
    timeunit 1ns;
    timeprecision 100ps;
    localparam int CONV  = 220;  // Shortened conversion
    localparam int ABORT = 50;   // Shortened abort window
    // Pins
    logic       mclk, rst_n, sclk, csN, dataIn, dataOut, dataOutEn;
    logic       eocOut, sampleEn, cmpHigh, syncLost, busOut;
    logic [3:0] chanSel;
    // Model and bookkeeping
    int         seed    = 51652;
    int         lastRes = -1;  // Result the next read returns; -1 when unknown
    int         nFail   = 0;
    int         nTests  = 0;
    int         cycles  = 0;
    // A released result line shows the inverse, never a friendly constant
    assign busOut = dataOutEn ? dataOut : ~dataOut;
    asq_sequencer #(.CONV_CYCLES(CONV), .ABORT_CYCLES(ABORT)) u_asq_sequencer (
        .mclk(mclk), .rst_n(rst_n), .sclk(sclk), .csN(csN), .dataIn(dataIn),
        .dataOut(dataOut), .dataOutEn(dataOutEn), .eocOut(eocOut),
        .analogChannelSel(chanSel), .sampleEn(sampleEn), .cmpHigh(cmpHigh),
        .syncLost(syncLost));
    asq_host u_host (.sclk(sclk), .csN(csN), .dataIn(dataIn), .dataOut(busOut));
    initial mclk = 1'b0;
    always #5 mclk = ~mclk;
    // Hang guard
    always @(posedge mclk)
    begin
        cycles++;
        if (cycles == 20000)
        begin
            nFail++;
            end_of_test();
        end
    end
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        nTests++;
        if (seen !== exp)
        begin
            nFail++;
            $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic end_of_test();
        $display("Comparisons %0d, mismatches %0d", nTests, nFail);
        if (nFail == 0 && nTests > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask
    // One transfer and its checks; the model advances unless aborted or desynced
    task automatic run(input int n, input int gapNs, input bit doAbort);
        logic [3:0]  addr;
        logic [15:0] rd;
        logic        cmpBit;
        addr   = 4'(($random(seed) & 32'hFF) % 5);
        cmpBit = doAbort ? (lastRes == 0) : 1'($random(seed));
        @(posedge mclk) #1 cmpHigh = cmpBit;
        u_host.xfer(n, addr, gapNs, rd);
        #20;
        // After a late rise the finished conversion restarts the frame: filler becomes address
        check(16'(chanSel), (gapNs > 0) ? {12'h000, ~addr[0], addr[0], ~addr[0], addr[0]}
                                        : 16'(addr));
        if (gapNs > 0)
            check(16'(syncLost), 16'h0001);
        else
            check(16'(eocOut), 16'h0000);
        if (lastRes >= 0 && gapNs == 0)
            check(rd, 16'(lastRes << 6));
        if (doAbort)
            u_host.abortPulse();
        else
            lastRes = (gapNs > 0) ? -1 : (cmpBit ? 1023 : 0);
        // Aborts must finish far sooner than a whole conversion
        for (int k = 0; k < (doAbort ? 60 : 400) && eocOut !== 1'b1; k++)
            #10;
        check(16'(eocOut), 16'h0001);
    endtask
    // Main sequence
    initial
    begin
        rst_n   = 1'b0;
        cmpHigh = 1'b0;
        repeat (5) @(posedge mclk);
        #1;
        check(16'({dataOutEn, eocOut, sampleEn, syncLost}), 16'h0004);
        rst_n = 1'b1;
        for (int n = 10; n <= 16; n++)
            run(n, 0, 1'b0);
        run(10, 0, 1'b1);
        run(12, 0, 1'b0);
        run(16, 20000, 1'b0);
        run(10, 0, 1'b0);
        check(16'(syncLost), 16'h0000);
        run(16, 0, 1'b0);
        end_of_test();
    end
endmodule
bind asq_sequencer asq_seq_chk #(.CONV_CYCLES(CONV_CYCLES), .ABORT_CYCLES(ABORT_CYCLES))
    u_asq_seq_chk (.mclk(mclk), .rst_n(rst_n), .sclk(sclk), .csN(csN), .dataOut(dataOut),
    .dataOutEn(dataOutEn), .eocOut(eocOut), .analogChannelSel(analogChannelSel),
    .sampleEn(sampleEn), .syncLost(syncLost));
`default_nettype wire
